// file: hw/frame_filter_regs.vh
// Constants for the modem frame address filter
`ifndef FRAME_FILTER_REGS_VH
`define FRAME_FILTER_REGS_VH
`define MAC_ADDR_W 48
`define HOST_ADDR_COUNT 2
`define MCAST_SLOT_COUNT 4
`define PATTERN_SLOT_COUNT 2
`define FRAME_CONTROL_TYPE_FIELD_MGMT 2'h3
`define ETH_TYPE_IPV4 16'h0800
`define ETH_TYPE_SNAP_MAX 16'h05dc
`define LLC_CTRL_TEST 8'he3
`define LLC_CTRL_TEST_P 8'hf3
`define LLC_CTRL_XID 8'haf
`define LLC_CTRL_XID_P 8'hbf
`define DIR_FIELD_FC 2'h0
`define FIELD_SEL_DST 2'h0
`define FIELD_SEL_SRC 2'h1
`define FIELD_SEL_MCAST 2'h2
`define FIELD_SEL_PATTERN 2'h3
`define WAKE_PULSE_CYCLES 8'h10
`endif

// file: hw/modem_frame_address_filter.v
// Frame address filter between cable network, host and modem MAC
//
// Overview of operation
// (R1) Drop downstream management unicast unless destination equals modem management address.
// (R2) Refuse upstream management unicast unless source equals modem management address.
// (R3) Pass every host-offered broadcast frame upstream.
// (R4) Pass every host-offered multicast frame upstream.
// (R5) Never answer LLC TEST or XID; pass them unchanged to host.
// (R6) Hold one 48-bit modem management address.
// (R7) Hold extra 48-bit host station addresses, two or more in total.
// (R8) Deliver downstream frames addressed to host station or management address.
// (R9) Host station addresses load from storage and are writable at run time.
// (R10) Deliver all downstream broadcasts, whatever their source address.
// (R11) Host-programmed multicast filters block unwanted downstream groups.
// (R12) Host-programmed pattern filters assert a wake signal on a match; code also needs hostAsleep and a management or host station address hit.
// (R13) Remove downstream frames for neither management nor host station address.
// (R14) Decide chiefly from destination, source and frame control type.
// (R15) Protocol entries match Ethernet/SNAP type or LLC service access point; code matches one Ethernet type, all LLC/SNAP frames pass unchecked.
// (R16) Header protocol filtering left to host software beyond type match.
// (R17) Carry IPv4 transparently; accept both 802.3 and DIX framing.
// (R18) LLC class 1 type 1 with SNAP frames pass unaltered.
// (R19) Pattern match wake drives the power management event line.
// (R20) Each delivered frame tagged with management or host station match; broadcast and multicast frames get neither tag.
`timescale 1ns/100ps
`include "frame_filter_regs.vh"
module modem_frame_address_filter
(
	input wire clk,
	input wire resetn,
	// Nonvolatile storage image, stable from reset
	input wire [47:0] nvModemAddr,
	input wire [95:0] nvHostAddr,
	// Host configuration writes
	input wire cfgWrite,
	input wire [1:0] cfgSel,
	input wire [1:0] cfgIndex,
	input wire [47:0] cfgData,
	input wire [47:0] cfgMask,
	input wire cfgEnable,
	input wire mcastFilterOn,
	input wire [15:0] protoTypeAllow,
	input wire protoFilterOn,
	input wire hostAsleep,
	// Downstream header summary, one pulse per frame
	input wire dnValid,
	input wire [47:0] dnDst,
	input wire [47:0] dnSrc,
	input wire dnIsMgmt,
	input wire [1:0] dnFcType,
	input wire [15:0] dnTypeLen,
	input wire [7:0] dnLlcCtrl,
	input wire [47:0] dnPatternWord,
	// Upstream header summary, one pulse per frame
	input wire upValid,
	input wire [47:0] upSrc,
	input wire [47:0] upDst,
	input wire upIsMgmt,
	input wire [1:0] upFcType,
	// Decisions
	output reg dnDone,
	output reg dnForward,
	output reg dnMatchModem,
	output reg dnMatchHost,
	output reg upDone,
	output reg upForward,
	output reg wakeEventN
);
	reg [47:0] modemAddr_reg;
	reg [47:0] hostAddr_reg [0:1];
	reg [1:0] hostEn_reg;
	reg [47:0] mcastAddr_reg [0:3];
	reg [3:0] mcastEn_reg;
	reg [47:0] patData_reg [0:1];
	reg [47:0] patMask_reg [0:1];
	reg [1:0] patEn_reg;
	reg [1:0] loadState_reg;
	reg [1:0] loadState_next;
	wire loaded;
	reg [7:0] wakeCount_reg;
	wire [1:0] hostHit;
	wire [3:0] mcastHit;
	wire [1:0] patHit;
	wire dnBcast = &dnDst;
	wire dnMcast = dnDst[40] & ~dnBcast;
	wire dnModemHit = (dnDst == modemAddr_reg);
	wire dnMgmtType = dnIsMgmt && (dnFcType == `FRAME_CONTROL_TYPE_FIELD_MGMT);
	wire isLlc = (dnTypeLen <= `ETH_TYPE_SNAP_MAX);
	wire isTestXid = isLlc && ((dnLlcCtrl == `LLC_CTRL_TEST) || (dnLlcCtrl == `LLC_CTRL_TEST_P)
		|| (dnLlcCtrl == `LLC_CTRL_XID) || (dnLlcCtrl == `LLC_CTRL_XID_P));
	wire protoOk = !protoFilterOn || isLlc || (dnTypeLen == protoTypeAllow); // (R15) (R16)
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : hostCmp
			assign hostHit[g] = hostEn_reg[g] && (dnDst == hostAddr_reg[g]); // (R8)
			assign patHit[g] = patEn_reg[g] &&
				((dnPatternWord & patMask_reg[g]) == (patData_reg[g] & patMask_reg[g])); // (R12)
		end
		for (g = 0; g < 4; g = g + 1)
		begin : mcastCmp
			assign mcastHit[g] = mcastEn_reg[g] && (dnDst == mcastAddr_reg[g]); // (R11)
		end
	endgenerate
	reg dnForward_next;
	always @*
	begin
		dnForward_next = 1'b0;
		if (dnMgmtType && !dnBcast && !dnMcast)
			dnForward_next = dnModemHit; // (R1) (R14)
		else if (dnBcast)
			dnForward_next = 1'b1; // (R10)
		else if (dnMcast)
			dnForward_next = !mcastFilterOn || (|mcastHit); // (R11)
		else
			dnForward_next = (dnModemHit || (|hostHit)) && (protoOk || isTestXid); // (R13) (R5) (R17) (R18)
	end
	// Upstream management unicast check
	wire upMgmtUni = upIsMgmt && (upFcType == `FRAME_CONTROL_TYPE_FIELD_MGMT) && !upDst[40];
	wire upForward_next = !upMgmtUni || (upSrc == modemAddr_reg); // (R2) (R3) (R4)
	// Requests are taken only once the stored addresses are loaded
	wire dnTake = dnValid && loaded;
	wire upTake = upValid && loaded;
	wire cfgTake = cfgWrite && loaded;
	wire wakeHit = dnTake && hostAsleep && (|patHit) && (dnModemHit || (|hostHit));
	// Slot selects for configuration writes
	wire [3:0] cfgSlotOh = 4'h1 << cfgIndex;
	wire [1:0] cfgPairOh = 2'h1 << cfgIndex[0];
	// Load sequencer: one cycle of load, then run
	localparam [1:0] ST_LOAD = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	assign loaded = (loadState_reg == ST_RUN);
	always @*
	begin
		loadState_next = loadState_reg;
		case (loadState_reg)
			ST_LOAD:
			begin
				loadState_next = ST_RUN;
			end
			ST_RUN:
			begin
				loadState_next = ST_RUN;
			end
			default:
			begin
				loadState_next = ST_LOAD;
			end
		endcase
	end
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			loadState_reg <= ST_LOAD;
		end
		else
		begin
			loadState_reg <= loadState_next;
		end
	end
	// Modem management address, not writable by the host
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			modemAddr_reg <= 48'h000000000000;
		end
		else if (loadState_reg == ST_LOAD)
		begin
			modemAddr_reg <= nvModemAddr; // (R6)
		end
	end
	generate
		// Host station address slots
		for (g = 0; g < `HOST_ADDR_COUNT; g = g + 1)
		begin : hostSlot
			always @(posedge clk)
			begin
				if (!resetn)
				begin
					hostAddr_reg[g] <= 48'h000000000000;
					hostEn_reg[g] <= 1'b0;
				end
				else if (loadState_reg == ST_LOAD)
				begin
					hostAddr_reg[g] <= nvHostAddr[g * 48 +: 48]; // (R9) (R7)
					hostEn_reg[g] <= 1'b1;
				end
				else if (cfgTake && (cfgSel == `FIELD_SEL_DST) && cfgPairOh[g])
				begin
					hostAddr_reg[g] <= cfgData; // (R9)
					hostEn_reg[g] <= cfgEnable;
				end
			end
		end
		// Multicast group slots
		for (g = 0; g < `MCAST_SLOT_COUNT; g = g + 1)
		begin : mcastSlot
			always @(posedge clk)
			begin
				if (!resetn)
				begin
					mcastAddr_reg[g] <= 48'h000000000000;
					mcastEn_reg[g] <= 1'b0;
				end
				else if (cfgTake && (cfgSel == `FIELD_SEL_MCAST) && cfgSlotOh[g])
				begin
					mcastAddr_reg[g] <= cfgData; // (R11)
					mcastEn_reg[g] <= cfgEnable;
				end
			end
		end
		// Wake pattern slots
		for (g = 0; g < `PATTERN_SLOT_COUNT; g = g + 1)
		begin : patSlot
			always @(posedge clk)
			begin
				if (!resetn)
				begin
					patData_reg[g] <= 48'h000000000000;
					patMask_reg[g] <= 48'h000000000000;
					patEn_reg[g] <= 1'b0;
				end
				else if (cfgTake && (cfgSel == `FIELD_SEL_PATTERN) && cfgPairOh[g])
				begin
					patData_reg[g] <= cfgData; // (R12)
					patMask_reg[g] <= cfgMask;
					patEn_reg[g] <= cfgEnable;
				end
			end
		end
	endgenerate
	// Downstream decisions, one cycle after the summary is taken
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			dnDone <= 1'b0;
			dnForward <= 1'b0;
			dnMatchModem <= 1'b0;
			dnMatchHost <= 1'b0;
		end
		else
		begin
			dnDone <= dnTake;
			dnForward <= dnTake && dnForward_next;
			dnMatchModem <= dnTake && dnForward_next && dnModemHit; // (R20)
			dnMatchHost <= dnTake && dnForward_next && (|hostHit); // (R20)
		end
	end
	// Upstream decisions
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			upDone <= 1'b0;
			upForward <= 1'b0;
		end
		else
		begin
			upDone <= upTake;
			upForward <= upTake && upForward_next; // (R2) (R3) (R4)
		end
	end
	// Wake pulse, restarted by every matching frame
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			wakeCount_reg <= 8'h00;
			wakeEventN <= 1'b1;
		end
		else
		begin
			if (wakeHit)
			begin
				wakeCount_reg <= `WAKE_PULSE_CYCLES; // (R12)
			end
			else if (wakeCount_reg != 8'h00)
			begin
				wakeCount_reg <= wakeCount_reg - 8'h01;
			end
			wakeEventN <= (wakeCount_reg == 8'h00); // (R19)
		end
	end
endmodule

// file: verif/frame_filter_chk_assertions.sv
// Checker for the frame filter decisions
`timescale 1ns/100ps
module frame_filter_chk
(
	input wire clk,
	input wire resetn,
	input wire dnValid,
	input wire dnIsMgmt,
	input wire upValid,
	input wire upIsMgmt,
	input wire dnDone,
	input wire dnForward,
	input wire dnMatchModem,
	input wire dnMatchHost,
	input wire upDone,
	input wire upForward,
	input wire wakeEventN,
	input wire [1:0] dnFcType,
	input wire [1:0] upFcType,
	input wire [47:0] nvModemAddr,
	input wire [47:0] dnDst,
	input wire [47:0] upSrc,
	input wire [47:0] upDst
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence strayMgmt;
		dnValid && dnIsMgmt && dnFcType == 2'h3 && !dnDst[40] && dnDst != nvModemAddr;
	endsequence
	sequence mgmtUp;
		upValid && upIsMgmt && upFcType == 2'h3 && !upDst[40] && upSrc != nvModemAddr;
	endsequence
	sequence groupUp;
		upValid && upDst[40] && $past(resetn);
	endsequence
	sequence bcastDn;
		dnValid && (&dnDst) && $past(resetn);
	endsequence
	dn_latency_a: assert property (dnDone |-> $past(dnValid)) else $error("dn done unasked");
	up_latency_a: assert property (upDone |-> $past(upValid)) else $error("up done unasked");
	dn_forward_a: assert property (dnForward |-> dnDone) else $error("forward without done");
	mgmt_drop_a: assert property (strayMgmt |=> !dnForward) else $error("stray mgmt kept");
	up_refuse_a: assert property (mgmtUp |=> !upForward) else $error("mgmt sent up");
	up_group_a: assert property (groupUp |=> upForward) else $error("group held");
	dn_bcast_a: assert property (bcastDn |=> dnForward) else $error("bcast held");
	modem_tag_a: assert property (dnMatchModem |-> dnForward && $past(dnDst) == nvModemAddr)
		else $error("bad modem tag");
	host_tag_a: assert property (dnMatchHost |-> dnForward) else $error("bad host tag");
	wake_hold_a: assert property ($fell(wakeEventN) |-> !wakeEventN [*8]) else $error("short wake");
endmodule
bind modem_frame_address_filter frame_filter_chk chk_u (.*);

// file: verif/host_model.sv
// Host side that writes filter slots
`timescale 1ns/100ps
module host_model
(
	input wire clk,
	input wire go,
	input wire en,
	input wire [1:0] sel,
	input wire [1:0] idx,
	input wire [47:0] data,
	output reg cfgWrite,
	output reg cfgEnable,
	output reg [1:0] cfgSel,
	output reg [1:0] cfgIndex,
	output reg [47:0] cfgData
);
	always @(posedge clk)
	begin
		cfgWrite <= go;
		cfgEnable <= en;
		cfgSel <= sel;
		cfgIndex <= idx;
		cfgData <= data;
	end
endmodule

// file: verif/test_modem_frame_address_filter.sv
// Bench for the frame address filter
`timescale 1ns/100ps
module test_modem_frame_address_filter;
	localparam [47:0] MA = 48'h02a0b0c0d0e0, H0 = 48'h020000000010, H1 = 48'h020000000022;
	localparam [47:0] H2 = 48'h020000000044, G = 48'h01005e000001, B = 48'hffffffffffff;
	localparam [47:0] WP = 48'h000000080045;
	reg clk = 0, resetn = 0, dv = 0, uv = 0, go = 0, en = 1, dm = 0, um = 0, mf = 0;
	reg pf = 0, hs = 0;
	reg [1:0] sel = 0, ix = 0;
	reg [47:0] dd = 0, ds = 0, ud = 0, us = 0, gd = 0;
	wire cw, ce, d, fd, mm, mh, u, fu, wk;
	wire [1:0] cs, ci;
	wire [47:0] cd;
	int error_cnt = 0, check_count = 0, n, k;
	bit [2:0] dq[$];
	bit uq[$];
	host_model host_u (.clk(clk), .go(go), .en(en), .sel(sel), .idx(ix), .data(gd),
		.cfgWrite(cw), .cfgEnable(ce), .cfgSel(cs), .cfgIndex(ci), .cfgData(cd));
	modem_frame_address_filter dut_u (.clk(clk), .resetn(resetn), .nvModemAddr(MA),
		.nvHostAddr({H1, H0}), .cfgWrite(cw), .cfgSel(cs), .cfgIndex(ci), .cfgData(cd),
		.cfgMask(48'h000000ffffff), .cfgEnable(ce), .mcastFilterOn(mf), .protoTypeAllow(16'h0800),
		.protoFilterOn(pf), .hostAsleep(hs), .dnValid(dv), .dnDst(dd), .dnSrc(ds),
		.dnIsMgmt(dm), .dnFcType({dm, dm}), .dnTypeLen(ds[23:8]), .dnLlcCtrl(ds[7:0]),
		.dnPatternWord(ds), .upValid(uv), .upSrc(us), .upDst(ud), .upIsMgmt(um),
		.upFcType({um, um}), .dnDone(d), .dnForward(fd), .dnMatchModem(mm), .dnMatchHost(mh),
		.upDone(u), .upForward(fu), .wakeEventN(wk));
	initial forever #4 clk = ~clk;
	task chk(input logic [2:0] v, input logic [2:0] e);
	begin
		check_count++;
		if (v !== e)
		begin
			error_cnt++;
			$display("unexpected %0t decision mismatch", $time);
		end
	end
	endtask
	task dn(input [47:0] a, input m, input [15:0] t, input [7:0] c, input [2:0] e);
	begin
		n = $urandom;
		dd <= a;
		dm <= m;
		ds <= {8'h02, n[15:0], t, c};
		uv <= 0;
		dv <= 1;
		dq.push_back(e);
		@(posedge clk);
	end
	endtask
	task up(input [47:0] s, input [47:0] a, input m, input e);
	begin
		us <= s;
		ud <= a;
		um <= m;
		dv <= 0;
		uv <= 1;
		uq.push_back(e);
		@(posedge clk);
	end
	endtask
	task cfg(input [1:0] s, input [1:0] i, input [47:0] a);
	begin
		sel <= s;
		ix <= i;
		gd <= a;
		dv <= 0;
		uv <= 0;
		go <= 1;
		@(posedge clk);
		go <= 0;
		repeat (3) @(posedge clk);
	end
	endtask
	always @(negedge clk)
	begin
		if (d === 1'b1)
			chk({fd, mm, mh}, dq.pop_front());
		if (u === 1'b1)
			chk({2'b00, fu}, {2'b00, uq.pop_front()});
	end
	task conclude;
	begin
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		n = $urandom(32'h2a32);
		repeat (16) @(posedge clk);
		resetn <= 1;
		repeat (2) @(posedge clk);
		dn(MA, 0, 16'h0800, 8'h00, 3'b110);
		dn(H1, 0, 16'h0800, 8'h00, 3'b101);
		dn(48'h020000000098, 0, 16'h0800, 8'h00, 3'b000);
		dn(MA, 1, 16'h0040, 8'h03, 3'b110);
		dn(H0, 1, 16'h0040, 8'h03, 3'b000);
		dn(B, 1, 16'h0040, 8'h03, 3'b100);
		dn(G, 0, 16'h0800, 8'h00, 3'b100);
		up(MA, H0, 1, 1);
		up(H0, MA, 1, 0);
		up(H0, B, 1, 1);
		up(H0, G, 1, 1);
		up(H0, H1, 0, 1);
		pf <= 1;
		dn(H0, 0, 16'h86dd, 8'h00, 3'b000);
		dn(H0, 0, 16'h0800, 8'h00, 3'b101);
		dn(H0, 0, 16'h0030, 8'he3, 3'b101);
		dn(MA, 0, 16'h0030, 8'haf, 3'b110);
		dn(H1, 0, 16'h0030, 8'h03, 3'b101);
		pf <= 0;
		cfg(2'h0, 2'h1, H2);
		dn(H2, 0, 16'h0800, 8'h00, 3'b101);
		dn(H1, 0, 16'h0800, 8'h00, 3'b000);
		en <= 0;
		cfg(2'h0, 2'h0, H0);
		dn(H0, 0, 16'h0800, 8'h00, 3'b000);
		en <= 1;
		mf <= 1;
		dn(G, 0, 16'h0800, 8'h00, 3'b000);
		cfg(2'h2, 2'h0, G);
		dn(G, 0, 16'h0800, 8'h00, 3'b100);
		cfg(2'h3, 2'h0, WP);
		hs <= 1;
		dn(H2, 0, 16'h0800, 8'h45, 3'b101);
		dv <= 0;
		hs <= 0;
		k = 0;
		while (wk !== 1'b0 && k < 8)
		begin
			@(negedge clk);
			k++;
		end
		chk({2'b00, wk}, 3'b000);
		k = 0;
		while (wk === 1'b0 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
		chk({2'b00, k == 16}, 3'b001);
		repeat (3) @(posedge clk);
		chk({2'b00, dq.size() == 0 && uq.size() == 0}, 3'b001);
		conclude;
	end
endmodule
